// ===== pdc_pkg.sv
// Purpose: Shared constants and types of the power-down controller.
// Assumes: 32-bit APB data, 16-bit byte addresses.
// Notes:   Each register sits in one aligned word, low bits used.
package pdc_pkg;

   // Register byte addresses
   localparam logic [15:0] ADDR_EDGE_SEL  = 16'hf1c0;
   localparam logic [15:0] ADDR_SYS_CFG   = 16'hf1c4;
   localparam logic [15:0] ADDR_RTC_CTRL  = 16'hf1c8;
   localparam logic [15:0] ADDR_WAKE_EN   = 16'hf1cc;
   localparam logic [15:0] ADDR_WAKE_FLAG = 16'hf1d0;
   localparam logic [15:0] ADDR_STATUS    = 16'hf1d4;

   // Reset values
   localparam logic [15:0] RST_EDGE_SEL = 16'h0000;
   localparam logic        RST_VARIANT  = 1'b0;
   localparam logic        RST_RTC_HALT = 1'b1;
   localparam logic [9:0]  RST_WAKE_EN  = 10'h000;

   // Field positions
   localparam int SYS_CFG_VARIANT_BIT = 0;
   localparam int RTC_HALT_BIT        = 0;
   localparam int WAKE_CAN_BIT        = 8;
   localparam int WAKE_I2C_BIT        = 9;
   localparam int STAT_STATE_LSB      = 0;
   localparam int STAT_LOCK_BIT       = 4;
   localparam int STAT_VARIANT_BIT    = 5;
   localparam int STAT_PINS_LSB       = 8;

   // Edge-select codes of one pin field
   localparam logic [1:0] EDGE_OFF  = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_ANY  = 2'h3;

   // Controller states
   typedef enum logic [1:0] {
      PDC_RUN,
      PDC_SLEEP_PROT,
      PDC_SLEEP_INT,
      PDC_WAKE_WAIT
   } pdc_state_t;

   // Power and clock controls driven to the clock generator
   typedef struct packed {
      logic clkGate;      // CPU and peripheral clocks frozen
      logic oscStop;      // Main oscillator stopped
      logic pllOff;       // PLL switched off
      logic rpdPullDown;  // Weak pull-down on wake_delay_pin
      logic lowSupply;    // Core supply lowered, state retained
   } pdc_pwr_t;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } pdc_apb_req_t;

endpackage : pdc_pkg

// ===== pdc_power_down_ctrl.sv
// Purpose: Power-down entry and exit control with APB registers.
// Assumes: clk is an always-on clock; pwr.clkGate freezes the CPU.
// Notes:   rst_n is the hardware reset input and ends any power-down.
`timescale 1ns/1ps

module pdc_power_down_ctrl #(
   parameter int NUM_PINS = 8
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire pdc_pkg::pdc_apb_req_t apbReq,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire logic                  sleepInstr,
   input  wire logic                  endOfInitInstr,
   input  wire logic                  nmi_n,
   input  wire logic [NUM_PINS-1:0]   fastExtIntPin,
   input  wire logic                  canRx,
   input  wire logic                  i2cScl,
   input  wire logic                  wakeDelayPin,
   output pdc_pkg::pdc_pwr_t          pwr,
   output logic                       sleepIgnored,
   output logic                       resumed,
   output logic                       wakeIrq
);
   import pdc_pkg::*;

   // Edge-select register holds two-bit fields for at most 8 pins
   if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_chk
      $error("NUM_PINS must lie between 1 and 8");
   end

   localparam int NSYNC = NUM_PINS + 4;

   // Entry allowed for one pin under its edge code
   function automatic logic entryOk(input logic [1:0] code,
                                    input logic       lvl);
      unique case (code)
         EDGE_OFF:  entryOk = 1'b1;
         EDGE_RISE: entryOk = !lvl;
         EDGE_FALL: entryOk = lvl;
         EDGE_ANY:  entryOk = 1'b1;
      endcase
   endfunction : entryOk

   // Wake condition of one pin; prev is its level at entry
   function automatic logic wakeHit(input logic [1:0] code,
                                    input logic       lvl,
                                    input logic       prev);
      unique case (code)
         EDGE_OFF:  wakeHit = 1'b0;
         EDGE_RISE: wakeHit = lvl;
         EDGE_FALL: wakeHit = !lvl;
         EDGE_ANY:  wakeHit = lvl != prev;
      endcase
   endfunction : wakeHit

   // Registers
   logic [15:0]         edgeSel;
   logic                variant;
   logic                cfgLocked;
   logic                rtcHalt;
   logic [9:0]          wakeEn;
   logic [9:0]          wakeFlag;
   pdc_state_t          state;
   logic [NSYNC-1:0]    syncA;
   logic [NSYNC-1:0]    syncB;
   logic [NUM_PINS-1:0] entryLvl;
   logic                canEntry;
   logic                i2cEntry;
   logic [1:0]          irqDelay;

   // Decoded signals
   logic [NUM_PINS-1:0] pinLvl;
   logic                nmiLow;
   logic                canLvl;
   logic                i2cLvl;
   logic                rpdLow;
   logic                allInactive;
   logic [9:0]          wakeSrc;
   logic                wakeNow;
   logic                setup;
   logic                access;
   logic                wrAccess;
   logic                hit;
   logic [31:0]         rdMux;
   logic [31:0]         statusWord;

   // Two-flop synchronisers; only syncB is read by any logic
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         syncA <= '0;
         syncB <= '0;
      end else begin
         syncA <= {wakeDelayPin, i2cScl, canRx, nmi_n, fastExtIntPin};
         syncB <= syncA;
      end
   end

   assign pinLvl = syncB[NUM_PINS-1:0];
   assign nmiLow = !syncB[NUM_PINS];
   assign canLvl = syncB[NUM_PINS+1];
   assign i2cLvl = syncB[NUM_PINS+2];
   assign rpdLow = !syncB[NUM_PINS+3];

   // Entry and wake evaluation per pin
   always_comb begin
      allInactive = 1'b1;
      wakeSrc = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (!entryOk(edgeSel[2*i +: 2], pinLvl[i])) begin
            allInactive = 1'b0;
         end
         // Enable bit plays no part in waking
         wakeSrc[i] = wakeHit(edgeSel[2*i +: 2], pinLvl[i],
                              entryLvl[i]);
      end
      wakeSrc[WAKE_CAN_BIT] = wakeEn[WAKE_CAN_BIT]
                              && (canLvl != canEntry);
      wakeSrc[WAKE_I2C_BIT] = wakeEn[WAKE_I2C_BIT]
                              && (i2cLvl != i2cEntry);
   end

   assign wakeNow = state == PDC_SLEEP_INT && |wakeSrc;

   // Power-down state machine; reset exits any state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= PDC_RUN;
      end else begin
         unique case (state)
            PDC_RUN: begin
               if (sleepInstr && !variant && nmiLow) begin
                  state <= PDC_SLEEP_PROT;
               end else if (sleepInstr && variant && allInactive) begin
                  state <= PDC_SLEEP_INT;
               end
            end
            PDC_SLEEP_PROT: begin
               state <= PDC_SLEEP_PROT;
            end
            PDC_SLEEP_INT: begin
               if (wakeNow) begin
                  state <= PDC_WAKE_WAIT;
               end
            end
            PDC_WAKE_WAIT: begin
               // Clocks stay gated until the RC delay has run out
               if (rpdLow) begin
                  state <= PDC_RUN;
               end
            end
         endcase
      end
   end

   // Pin levels captured at entry, reference for any-edge wake
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         entryLvl <= '0;
         canEntry <= 1'b0;
         i2cEntry <= 1'b0;
      end else if (state == PDC_RUN) begin
         entryLvl <= pinLvl;
         canEntry <= canLvl;
         i2cEntry <= i2cLvl;
      end
   end

   // Refused and resume strobes towards the CPU
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sleepIgnored <= 1'b0;
         resumed      <= 1'b0;
      end else begin
         sleepIgnored <= state == PDC_RUN && sleepInstr
                         && (variant ? !allInactive : !nmiLow);
         resumed      <= state == PDC_WAKE_WAIT && rpdLow;
      end
   end

   // Clock and supply controls; registered so they never glitch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwr <= '0;
      end else begin
         pwr.clkGate     <= state != PDC_RUN;
         // Oscillator survives while the RTC counts
         pwr.oscStop     <= (state == PDC_SLEEP_INT
                             || state == PDC_SLEEP_PROT)
                            && rtcHalt;
         pwr.pllOff      <= state == PDC_SLEEP_INT
                            || state == PDC_SLEEP_PROT;
         pwr.rpdPullDown <= state == PDC_WAKE_WAIT;
         pwr.lowSupply   <= state == PDC_SLEEP_INT
                            || state == PDC_SLEEP_PROT;
      end
   end

   // APB decode; zero wait states
   assign setup    = apbReq.psel && !apbReq.penable;
   assign access   = apbReq.psel && apbReq.penable;
   assign wrAccess = access && apbReq.pwrite && !pslverr;
   assign pready   = access;

   always_comb begin
      hit = 1'b1;
      unique case (apbReq.paddr)
         ADDR_EDGE_SEL:  rdMux = {16'h0000, edgeSel};
         ADDR_SYS_CFG:   rdMux = {31'h0000_0000, variant};
         ADDR_RTC_CTRL:  rdMux = {31'h0000_0000, rtcHalt};
         ADDR_WAKE_EN:   rdMux = {22'h00_0000, wakeEn};
         ADDR_WAKE_FLAG: rdMux = {22'h00_0000, wakeFlag};
         ADDR_STATUS:    rdMux = statusWord;
         default: begin
            rdMux = 32'h0000_0000;
            hit   = 1'b0;
         end
      endcase
   end

   // Status word shows the controller's own state
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[STAT_STATE_LSB +: 2]       = state;
      statusWord[STAT_LOCK_BIT]             = cfgLocked;
      statusWord[STAT_VARIANT_BIT]          = variant;
      statusWord[STAT_PINS_LSB +: NUM_PINS] = pinLvl;
   end

   // Read data and error captured at setup, held through access
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= apbReq.pwrite ? 32'h0000_0000 : rdMux;
         pslverr <= !hit;
      end
   end

   // Edge-select fields
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         edgeSel <= RST_EDGE_SEL;
      end else if (wrAccess && apbReq.paddr == ADDR_EDGE_SEL) begin
         edgeSel <= apbReq.pwdata[15:0];
      end
   end

   // Variant bit, frozen once initialisation has ended
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         variant   <= RST_VARIANT;
         cfgLocked <= 1'b0;
      end else begin
         if (endOfInitInstr) begin
            cfgLocked <= 1'b1;
         end
         if (wrAccess && apbReq.paddr == ADDR_SYS_CFG && !cfgLocked) begin
            variant <= apbReq.pwdata[SYS_CFG_VARIANT_BIT];
         end
      end
   end

   // RTC halt bit decides whether the oscillator may stop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rtcHalt <= RST_RTC_HALT;
      end else if (wrAccess && apbReq.paddr == ADDR_RTC_CTRL) begin
         rtcHalt <= apbReq.pwdata[RTC_HALT_BIT];
      end
   end

   // Wake interrupt enables; bits 8 and 9 also arm CAN and I2C wake
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wakeEn <= RST_WAKE_EN;
      end else if (wrAccess && apbReq.paddr == ADDR_WAKE_EN) begin
         wakeEn <= apbReq.pwdata[9:0];
      end
   end

   // Request flags: write one to clear, a new wake wins the clash
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wakeFlag <= '0;
      end else begin
         for (int i = 0; i < 10; i++) begin
            if (wakeNow && wakeSrc[i]) begin
               wakeFlag[i] <= 1'b1;
            end else if (wrAccess && apbReq.paddr == ADDR_WAKE_FLAG
                         && apbReq.pwdata[i]) begin
               wakeFlag[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt held back three cycles after the resume pulse, so the CPU
   // completes the instruction after the sleep first
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irqDelay <= 2'h0;
      end else if (state != PDC_RUN) begin
         irqDelay <= 2'h0;
      end else if (irqDelay != 2'h2) begin
         irqDelay <= irqDelay + 2'h1;
      end
   end

   // Only enabled flags reach the CPU; disabled ones just stay set
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wakeIrq <= 1'b0;
      end else begin
         wakeIrq <= irqDelay == 2'h2
                    && |(wakeFlag & wakeEn);
      end
   end

endmodule : pdc_power_down_ctrl

// ===== pdc_assertions.sv
// Purpose: Port-level checks of the power-down controller.
// Assumes: Sees only the controller ports; clk and rst_n one domain.
// Notes:   Variant bit is mirrored from APB writes, frozen after init.
`timescale 1ns/1ps
module pdc_assertions
   import pdc_pkg::*;
#(
   parameter int NUM_PINS = 8
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire pdc_pkg::pdc_apb_req_t apbReq,
   input wire logic              sleepInstr,
   input wire logic              endOfInitInstr,
   input wire logic              nmi_n,
   input wire logic              wakeDelayPin,
   input wire pdc_pkg::pdc_pwr_t pwr,
   input wire logic              sleepIgnored,
   input wire logic              resumed,
   input wire logic              wakeIrq
);
   logic variant;
   logic locked;

   // Mirror of the variant bit, since the checker cannot see registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         variant <= RST_VARIANT;
         locked  <= 1'h0;
      end else begin
         if (endOfInitInstr) locked <= 1'h1;
         if (apbReq.psel && apbReq.penable && apbReq.pwrite && !locked
             && apbReq.paddr == ADDR_SYS_CFG) variant <= apbReq.pwdata[0];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Four samples cover the two-flop synchroniser delay
   sequence nmiHigh; nmi_n [*4]; endsequence
   sequence nmiLow;  !nmi_n [*4]; endsequence

   a_prot_refuse: assert property (nmiHigh ##0 (sleepInstr && !variant)
      |=> sleepIgnored) else $error("protected sleep not refused");
   a_prot_enter: assert property (nmiLow ##0 (sleepInstr && !variant)
      |-> ##2 pwr.clkGate) else $error("protected sleep not entered");
   a_prot_no_wake: assert property (pwr.clkGate && !variant
      |-> !pwr.rpdPullDown) else $error("protected sleep woke up");
   a_gate_cause: assert property ($rose(pwr.clkGate)
      |-> $past(sleepInstr, 2)) else $error("clock gated without sleep");
   a_gate_set: assert property ($rose(pwr.clkGate)
      |-> pwr.pllOff && pwr.lowSupply) else $error("pll or supply");
   a_refuse_pulse: assert property (sleepIgnored |-> $past(sleepInstr)
      && !pwr.clkGate ##1 !sleepIgnored && !pwr.clkGate)
      else $error("refusal pulse wrong");
   a_wake_pull: assert property ($rose(pwr.rpdPullDown)
      |-> pwr.clkGate && !pwr.pllOff && !pwr.oscStop)
      else $error("wake did not restart clocks");
   a_resume_rc: assert property (resumed |-> !$past(wakeDelayPin, 3)
      ##1 (!pwr.clkGate && !resumed)) else $error("resume before delay");
   a_irq_late: assert property ($rose(wakeIrq) |-> $past(resumed, 3))
      else $error("service call not after next instruction");
endmodule : pdc_assertions

bind pdc_power_down_ctrl pdc_assertions #(.NUM_PINS(NUM_PINS)) chk (
   .clk(clk), .rst_n(rst_n), .apbReq(apbReq), .sleepInstr(sleepInstr),
   .endOfInitInstr(endOfInitInstr), .nmi_n(nmi_n),
   .wakeDelayPin(wakeDelayPin), .pwr(pwr), .sleepIgnored(sleepIgnored),
   .resumed(resumed), .wakeIrq(wakeIrq));

// ===== pdc_rc_network.sv
// Purpose: External RC network on the wake delay pin.
// Assumes: Comparator output, low once the capacitor is discharged.
// Notes:   Recharge is instant; discharge time is set by rcDelay.
`timescale 1ns/1ps
module pdc_rc_network (
   input wire logic       clk,
   input wire logic       pullDown,
   input wire logic [7:0] rcDelay,
   output logic           wakeDelayPin
);
   logic [7:0] dischargeCnt;

   // Counts only while the weak pull-down drains the capacitor
   always_ff @(posedge clk) begin
      if (!pullDown) dischargeCnt <= 8'h00;
      else if (dischargeCnt != rcDelay) dischargeCnt <= dischargeCnt + 8'h01;
   end
   assign wakeDelayPin = !(pullDown && dischargeCnt == rcDelay);
endmodule : pdc_rc_network

// ===== pdc_power_down_ctrl_bench.sv
// Purpose: Self-checking bench of the power-down controller.
// Assumes: 200 MHz clock, zero-wait APB, fixed seed 75.
// Notes:   Pins are set four cycles ahead of sleep for the synchroniser.
`timescale 1ns/1ps
module pdc_power_down_ctrl_bench;
   import pdc_pkg::*;
   logic         clk = 1'h0;
   logic         rst_n = 1'h0;
   pdc_apb_req_t apbReq = '0;
   logic         sleepInstr = 1'h0;
   logic         endOfInitInstr = 1'h0;
   logic         nmi_n = 1'h1;
   logic [7:0]   pins = 8'h00;
   logic         canRx = 1'h0;
   logic         i2cScl = 1'h0;
   logic [7:0]   rcDelay = 8'h08;
   logic         pready, pslverr, sleepIgnored, resumed, wakeIrq, rcPin;
   logic [31:0]  prdata, rd, x;
   pdc_pwr_t     pwr;
   logic [1:0]   code;
   logic [7:0]   en;
   logic         err, gate, ign, lvl, halt;
   int           fails = 0, totalChecks = 0, seed = 75, cycles = 0, i, k, n;

   pdc_power_down_ctrl #(.NUM_PINS(8)) dut (.clk(clk), .rst_n(rst_n),
      .apbReq(apbReq), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sleepInstr(sleepInstr), .endOfInitInstr(endOfInitInstr),
      .nmi_n(nmi_n), .fastExtIntPin(pins), .canRx(canRx), .i2cScl(i2cScl),
      .wakeDelayPin(rcPin), .pwr(pwr), .sleepIgnored(sleepIgnored),
      .resumed(resumed), .wakeIrq(wakeIrq));
   pdc_rc_network rc (.clk(clk), .pullDown(pwr.rpdPullDown),
      .rcDelay(rcDelay), .wakeDelayPin(rcPin));

   // Clock and hang guard
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         finishTest;
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One APB transfer; request held until pready is seen at an edge
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      n = 0;
      @(posedge clk);
      apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      apbReq.penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      apbReq <= '0;
   endtask : apb

   task sleep;
      @(posedge clk);
      sleepInstr <= 1'h1;
      @(posedge clk);
      sleepInstr <= 1'h0;
      // Refusal pulse stands only in the cycle after the sleep edge
      #1;
      ign = sleepIgnored;
      @(posedge clk);
      #1;
      gate = pwr.clkGate;
   endtask : sleep

   // Entry is blocked only by a rise or fall pin already active
   function automatic logic mayEnter(input logic [1:0] c, input logic l);
      return !((c == EDGE_RISE && l) || (c == EDGE_FALL && !l));
   endfunction : mayEnter

   task finishTest;
      $display("checks %0d mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finishTest

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      apb(1'h0, ADDR_EDGE_SEL, 32'h0);
      check(rd, {16'h0, RST_EDGE_SEL});
      apb(1'h0, 16'hf1f0, 32'h0);
      check({err, rd}, 33'h1_0000_0000);
      x = $random(seed);
      apb(1'h1, ADDR_EDGE_SEL, x);
      apb(1'h0, ADDR_EDGE_SEL, 32'h0);
      check(rd, x & 32'h0000_ffff);
      // Protected: refused with NMI high, entered with it low
      apb(1'h1, ADDR_EDGE_SEL, 32'h0000_5555);
      sleep;
      check({ign, gate}, 2'h2);
      @(posedge clk);
      nmi_n <= 1'h0;
      repeat (4) @(posedge clk);
      sleep;
      check(gate, 1'h1);
      @(posedge clk);
      nmi_n <= 1'h1;
      pins <= 8'hff;
      canRx <= 1'h1;
      repeat (20) @(posedge clk);
      #1;
      check({pwr.clkGate, pwr.rpdPullDown, pwr.lowSupply}, 3'h5);
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      pins <= 8'h00;
      #1;
      check(pwr.clkGate, 1'h0);
      // Interruptible: every edge code, random pin, level, enable and RTC
      apb(1'h1, ADDR_SYS_CFG, 32'h1);
      for (i = 0; i < 8; i++) begin
         code = i[1:0];
         k = $random(seed) & 7;
         lvl = $random(seed);
         en = $random(seed);
         halt = $random(seed);
         apb(1'h1, ADDR_EDGE_SEL, 32'(code) << (2 * k));
         apb(1'h1, ADDR_WAKE_EN, {22'h0, i[2], !i[2], en});
         apb(1'h1, ADDR_RTC_CTRL, {31'h0, halt});
         @(posedge clk);
         pins[k] <= lvl;
         rcDelay <= 8'h08 + 8'($random(seed) & 31);
         repeat (4) @(posedge clk);
         sleep;
         check({ign, gate}, {!mayEnter(code, lvl), mayEnter(code, lvl)});
         if (gate) begin
            check({pwr.oscStop, pwr.pllOff}, {halt, 1'h1});
            @(posedge clk);
            pins[k] <= !lvl;
            if (code == EDGE_OFF) begin
               repeat (10) @(posedge clk);
               #1;
               check(pwr.rpdPullDown, 1'h0);
               @(posedge clk);
               if (i[2]) i2cScl <= !i2cScl;
               else canRx <= !canRx;
            end
            repeat (8) @(posedge clk);
            #1;
            check({pwr.rpdPullDown, pwr.pllOff}, 2'h2);
            pins[k] <= lvl;
            for (n = 0; n < 80 && resumed !== 1'h1; n++) begin
               @(posedge clk);
               #1;
            end
            check(resumed, 1'h1);
            // Clocks open one cycle after the resume pulse
            @(posedge clk);
            #1;
            check({resumed, pwr.clkGate}, 2'h0);
            repeat (2) @(posedge clk);
            #1;
            check(wakeIrq, (code == EDGE_OFF) ? 1'h1 : en[k]);
            apb(1'h0, ADDR_WAKE_FLAG, 32'h0);
            check(rd != 32'h0, 1'h1);
            apb(1'h1, ADDR_WAKE_FLAG, 32'h0000_03ff);
            @(posedge clk);
            #1;
            check(wakeIrq, 1'h0);
         end
      end
      // Variant bit frozen once init has ended
      @(posedge clk);
      endOfInitInstr <= 1'h1;
      @(posedge clk);
      endOfInitInstr <= 1'h0;
      apb(1'h1, ADDR_SYS_CFG, 32'h0);
      apb(1'h0, ADDR_SYS_CFG, 32'h0);
      check({err, rd}, 33'h1);
      finishTest;
   end
endmodule : pdc_power_down_ctrl_bench
